// *** src/verify_code_pkg.sv ***
// Constants shared by the verification code sequencer and its delay counter
package verify_code_pkg;
  // ************************************************************
  // Clock and timebase
  // ************************************************************
  localparam int CLK_HZ = 20000000;
  localparam int OSC_HZ = 74565;
  localparam int OSC_DIV = CLK_HZ / OSC_HZ;
  localparam int OSC_DIV_W = 9;
  localparam int DIV_W = 14;
  // Divider tap numbers: tap n has a period of 2**n oscillator cycles
  localparam int TAP_DELAY = 7;
  localparam int TAP_FAST32 = 8;
  localparam int TAP_FAST16 = 9;
  localparam int TAP_FAST8 = 10;
  localparam int TAP_SLOW = 13;
  localparam int TAP_SYNC = 14;
  localparam logic [1:0] SPEED_X8 = 2'h0;
  localparam logic [1:0] SPEED_X16 = 2'h1;
  // ************************************************************
  // Sequence figures
  // ************************************************************
  localparam int CODE_BITS = 9;
  localparam logic [2:0] SYNC_WAIT_TICKS = 3'h5;
  localparam logic [2:0] SYNC_PULSE_TICKS = 3'h3;
  localparam logic [2:0] GAP_TICKS = 3'h4;
  localparam logic [1:0] ONE_UNITS = 2'h3;
  localparam logic [1:0] ZERO_UNITS = 2'h1;
  localparam logic [1:0] SPACE_UNITS = 2'h3;
  localparam logic [3:0] SLOTS = 4'hC;
  localparam logic [2:0] CYCLE_CLOSE = 3'h3;
  localparam logic [2:0] CYCLE_END = 3'h4;
  localparam int DELAY_LOG2 = 11;
  // ************************************************************
  // Sequence states, Gray coded along the path except the gap to sync wait step
  // ************************************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_SYNC_WAIT = 3'h1,
    ST_SYNC_PULSE = 3'h3,
    ST_GAP = 3'h2,
    ST_BITS = 3'h6
  } seq_state_t;
endpackage

// *** src/tick_delay_counter.sv ***
// Delay counter that counts timebase ticks while enabled and then holds its output
`timescale 1ns/10ps
module tick_delay_counter
  import verify_code_pkg::*;
#(
  parameter int LOG2_TICKS = DELAY_LOG2
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic enable,
  input wire logic tick,
  output logic done
);
  logic [LOG2_TICKS:0] cnt_ff;
  logic [LOG2_TICKS:0] nxt_cnt;

  // Count while enabled; terminal stage gates off further ticks
  always_comb begin
    nxt_cnt = cnt_ff;
    if (!enable) begin
      nxt_cnt = '0;
    end else if (tick && !cnt_ff[LOG2_TICKS]) begin
      nxt_cnt = cnt_ff + 1'b1;
    end
  end

  // Counter register
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  assign done = cnt_ff[LOG2_TICKS]; // Terminal stage only
endmodule

// *** src/channel_verify_code_sequencer.sv ***
// Channel verification code sequencer with selection and energize delays
//
// What this block does
// - Selection delay end starts sequence; priority low until closing sync and gap finish.
// - Sync phase counter counts five sync taps, then code output goes high.
// - Sync pulse lasts three sync tap periods at any code speed.
// - Gap counts four code clocks, releases bit logic, advances cycle counter.
// - Channel bits load in parallel into the shift register on first bit clock.
// - Then the register switches to shifting, one stored bit per bit period.
// - A one is three code clocks high, a zero one code clock high.
// - When group counter low bits are zero, code stays low three code clocks.
// - After twelve bit slots (nine pulses, three spaces), bit logic resets and gap counting restarts.
// - The 9-bit code goes out twice, each cycle preceded by a gap.
// - At cycle count three the sync phase restarts, then a closing sync follows.
// - Fourth cycle increment after closing sync ends sequence and releases priority.
// - Code output is driven in inverted polarity.
// - Execute tone after selection counts 2048 delay taps, then energize asserts.
// - Energize stays high until its enabling condition is removed.
// - Energize is driven only from the energize counter terminal stage.
// - Code clock is slow tap, or a jumper-chosen 8x, 16x or 32x tap.
// - Selection delay counts 2048 delay taps, holds high, its rise starts sequence.
// - All sequence state is reset at power-up and while idle.
// - Removing the execute tone resets energize; its fall starts a new sequence.
`timescale 1ns/10ps
module channel_verify_code_sequencer
  import verify_code_pkg::*;
#(
  parameter int OSC_DIVIDE = OSC_DIV,
  parameter int TAP_SHIFT = 0 // Moves every tap down alike; nonzero only to shorten timing
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [CODE_BITS-1:0] chan_code,
  input wire logic chan_selected,
  input wire logic exec_tone,
  input wire logic fast_mode,
  input wire logic [1:0] speed_sel,
  output logic priority_n,
  output logic code_out_n,
  output logic energize
);
  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  localparam int PIN_W = CODE_BITS + 5;
  logic [PIN_W-1:0] pin_meta_ff;
  logic [PIN_W-1:0] pin_ff;
  logic [CODE_BITS-1:0] code_pins;
  logic sel_s;
  logic exec_s;
  logic fast_s;
  logic [1:0] speed_s;

  // Two flops ahead of any logic
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pin_meta_ff <= '0;
      pin_ff <= '0;
    end else begin
      pin_meta_ff <= {chan_code, chan_selected, exec_tone, fast_mode, speed_sel};
      pin_ff <= pin_meta_ff;
    end
  end

  assign {code_pins, sel_s, exec_s, fast_s, speed_s} = pin_ff;

  // ************************************************************
  // Timebase divider
  // ************************************************************
  logic [OSC_DIV_W-1:0] pre_ff;
  logic [OSC_DIV_W-1:0] nxt_pre;
  logic [DIV_W-1:0] div_ff;
  logic [DIV_W-1:0] nxt_div;
  logic osc_tick;
  logic [DIV_W:1] tap_rise;
  logic sync_tick;
  logic delay_tick;
  logic code_tick;

  // Oscillator emulation and one binary chain for every tap
  always_comb begin
    osc_tick = (pre_ff == OSC_DIV_W'(OSC_DIVIDE - 1));
    nxt_pre = osc_tick ? '0 : pre_ff + 1'b1;
    nxt_div = osc_tick ? div_ff + 1'b1 : div_ff;
    tap_rise = osc_tick ? (~div_ff & nxt_div) : '0;
  end

  // Divider registers
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pre_ff <= '0;
      div_ff <= '0;
    end else begin
      pre_ff <= nxt_pre;
      div_ff <= nxt_div;
    end
  end

  // Tap selection
  always_comb begin
    sync_tick = tap_rise[TAP_SYNC - TAP_SHIFT];
    delay_tick = tap_rise[TAP_DELAY - TAP_SHIFT];
    if (!fast_s) begin
      code_tick = tap_rise[TAP_SLOW - TAP_SHIFT];
    end else if (speed_s == SPEED_X8) begin
      code_tick = tap_rise[TAP_FAST8 - TAP_SHIFT];
    end else if (speed_s == SPEED_X16) begin
      code_tick = tap_rise[TAP_FAST16 - TAP_SHIFT];
    end else begin
      code_tick = tap_rise[TAP_FAST32 - TAP_SHIFT];
    end
  end

  // ************************************************************
  // Selection and energize delays
  // ************************************************************
  logic sel_done;
  logic exec_en;
  logic sel_done_d_ff;
  logic energize_d_ff;
  logic start_evt;

  tick_delay_counter #(.LOG2_TICKS(DELAY_LOG2)) selection_delay_counter (
    .mclk(mclk),
    .arst_n(arst_n),
    .enable(sel_s),
    .tick(delay_tick),
    .done(sel_done)
  );

  assign exec_en = sel_done & exec_s;

  tick_delay_counter #(.LOG2_TICKS(DELAY_LOG2)) energize_counter (
    .mclk(mclk),
    .arst_n(arst_n),
    .enable(exec_en),
    .tick(delay_tick),
    .done(energize)
  );

  // Edge history for sequence triggers
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sel_done_d_ff <= 1'b0;
      energize_d_ff <= 1'b0;
    end else begin
      sel_done_d_ff <= sel_done;
      energize_d_ff <= energize;
    end
  end

  // Selection rise or energize fall
  assign start_evt = (sel_done & ~sel_done_d_ff) | (~energize & energize_d_ff);

  // ************************************************************
  // Verification code sequence
  // ************************************************************
  seq_state_t state_ff;
  seq_state_t nxt_state;
  logic active_ff;
  logic nxt_active;
  logic [2:0] cnt_ff;
  logic [2:0] nxt_cnt;
  logic [2:0] cycle_ff;
  logic [2:0] nxt_cycle;
  logic [3:0] slot_ff;
  logic [3:0] nxt_slot;
  logic [1:0] unit_ff;
  logic [1:0] nxt_unit;
  logic load_ff;
  logic nxt_load;
  logic [CODE_BITS-1:0] shift_ff;
  logic [CODE_BITS-1:0] nxt_shift;
  logic code_ff;
  logic nxt_code;
  logic space_slot;
  logic [1:0] high_units;
  logic [1:0] slot_last;
  logic [1:0] nxt_high;

  // Next state of the sequencer
  always_comb begin
    nxt_state = state_ff;
    nxt_active = active_ff;
    nxt_cnt = cnt_ff;
    nxt_cycle = cycle_ff;
    nxt_slot = slot_ff;
    nxt_unit = unit_ff;
    nxt_load = load_ff;
    nxt_shift = shift_ff;
    space_slot = (slot_ff[1:0] == 2'h0);
    high_units = shift_ff[CODE_BITS-1] ? ONE_UNITS : ZERO_UNITS;
    slot_last = space_slot ? SPACE_UNITS - 2'h1 : high_units;
    unique case (state_ff)
      ST_IDLE: begin
        nxt_cycle = '0;
        nxt_cnt = '0;
        nxt_slot = '0;
        nxt_unit = '0;
        nxt_load = 1'b0;
        nxt_shift = '0;
        if (start_evt) begin
          nxt_state = ST_SYNC_WAIT;
          nxt_active = 1'b1;
        end
      end
      ST_SYNC_WAIT: begin
        if (sync_tick) begin
          if (cnt_ff == SYNC_WAIT_TICKS - 3'h1) begin
            nxt_state = ST_SYNC_PULSE;
            nxt_cnt = '0;
          end else begin
            nxt_cnt = cnt_ff + 3'h1;
          end
        end
      end
      ST_SYNC_PULSE: begin
        if (sync_tick) begin
          if (cnt_ff == SYNC_PULSE_TICKS - 3'h1) begin
            nxt_state = ST_GAP;
            nxt_cnt = '0;
          end else begin
            nxt_cnt = cnt_ff + 3'h1;
          end
        end
      end
      ST_GAP: begin
        if (code_tick) begin
          if (cnt_ff == GAP_TICKS - 3'h1) begin
            nxt_cnt = '0;
            nxt_cycle = cycle_ff + 3'h1;
            if (cycle_ff + 3'h1 == CYCLE_END) begin
              nxt_state = ST_IDLE;
              nxt_active = 1'b0;
            end else if (cycle_ff + 3'h1 == CYCLE_CLOSE) begin
              nxt_state = ST_SYNC_WAIT;
            end else begin
              nxt_state = ST_BITS;
              nxt_slot = '0;
              nxt_unit = '0;
              nxt_load = 1'b1;
              nxt_shift = code_pins;
            end
          end else begin
            nxt_cnt = cnt_ff + 3'h1;
          end
        end
      end
      ST_BITS: begin
        if (code_tick) begin
          if (unit_ff == slot_last) begin
            nxt_unit = '0;
            nxt_load = 1'b0;
            if (!space_slot) begin
              nxt_shift = {shift_ff[CODE_BITS-2:0], 1'b0};
            end
            if (slot_ff == SLOTS - 4'h1) begin
              nxt_state = ST_GAP;
            end else begin
              nxt_slot = slot_ff + 4'h1;
            end
          end else begin
            nxt_unit = unit_ff + 2'h1;
          end
        end
      end
      default: begin
        nxt_state = ST_IDLE;
        nxt_active = 1'b0;
      end
    endcase
    // Code level for the coming unit
    nxt_high = nxt_shift[CODE_BITS-1] ? ONE_UNITS : ZERO_UNITS;
    nxt_code = (nxt_state == ST_SYNC_PULSE) ||
               ((nxt_state == ST_BITS) && (nxt_slot[1:0] != 2'h0) && (nxt_unit < nxt_high));
  end

  // Sequencer registers; idle clears everything
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= ST_IDLE;
      active_ff <= 1'b0;
      cnt_ff <= '0;
      cycle_ff <= '0;
      slot_ff <= '0;
      unit_ff <= '0;
      load_ff <= 1'b0;
      shift_ff <= '0;
      code_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      active_ff <= nxt_active;
      cnt_ff <= nxt_cnt;
      cycle_ff <= nxt_cycle;
      slot_ff <= nxt_slot;
      unit_ff <= nxt_unit;
      load_ff <= nxt_load;
      shift_ff <= nxt_shift;
      code_ff <= nxt_code;
    end
  end

  assign priority_n = ~active_ff;
  assign code_out_n = ~code_ff;

  // ************************************************************
  // Checks
  // ************************************************************
  logic [2:0] hi_run_ff;

  // High width of the code in code clocks
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      hi_run_ff <= '0;
    end else if (!code_ff) begin
      hi_run_ff <= '0;
    end else if (code_tick && hi_run_ff != 3'h7) begin
      hi_run_ff <= hi_run_ff + 3'h1;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  sequence s_gap_done;
    state_ff == ST_GAP && code_tick && cnt_ff == GAP_TICKS - 3'h1;
  endsequence

  sequence s_sync_done;
    state_ff == ST_SYNC_PULSE && sync_tick && cnt_ff == SYNC_PULSE_TICKS - 3'h1;
  endsequence

  a_priority_start: assert property (
    state_ff == ST_IDLE && start_evt |=> !priority_n && state_ff == ST_SYNC_WAIT)
    else $error("priority not taken at sequence start");
  a_sync_wait_low: assert property (
    state_ff == ST_SYNC_WAIT && sync_tick && cnt_ff == 3'h4 |-> !code_ff ##1 code_ff)
    else $error("sync pulse did not start after five sync ticks");
  a_sync_pulse_end: assert property (
    s_sync_done |=> state_ff == ST_GAP && !code_ff)
    else $error("sync pulse did not end after three sync ticks");
  a_gap_cycle_step: assert property (
    s_gap_done |=> cycle_ff == $past(cycle_ff) + 3'h1)
    else $error("cycle counter did not advance after gap");
  a_pulse_width: assert property (
    $fell(code_ff) && $past(state_ff) == ST_BITS |-> hi_run_ff == 3'h1
      || hi_run_ff == 3'h3)
    else $error("code pulse is neither one nor three units");
  a_load_mode: assert property (
    state_ff == ST_BITS |-> load_ff == (slot_ff == 4'h0))
    else $error("load mode not held for the first slot only");
  a_group_space: assert property (
    state_ff == ST_BITS && slot_ff[1:0] == 2'h0 |-> !code_ff)
    else $error("code high during group space");
  a_closing_sync: assert property (
    s_gap_done and cycle_ff == 3'h2 |=> state_ff == ST_SYNC_WAIT && !code_ff)
    else $error("closing sync phase not restarted");
  a_end_release: assert property (
    s_gap_done and cycle_ff == 3'h3 |=> priority_n && state_ff == ST_IDLE)
    else $error("priority not released at sequence end");
  a_energize_hold: assert property (
    energize && exec_en |=> energize)
    else $error("energize dropped while enabled");
  a_energize_clear: assert property (
    !exec_en |=> !energize)
    else $error("energize not reset when enable removed");
endmodule

// *** verification/ground_decoder_model.sv ***
// Ground-side decoder model that measures code pulse and pause lengths
`timescale 1ns/10ps
module ground_decoder_model (
  input wire logic mclk,
  input wire logic priority_n,
  input wire logic code_out_n,
  output logic pulse_seen,
  output int hi_len,
  output int lo_len
);
  // ************************************************************
  // Pulse width measurement
  // ************************************************************
  int run_cnt = 1;
  logic prev_code = 1'b0;
  // Count falling-edge samples of each level, where outputs have settled
  always @(negedge mclk) begin
    pulse_seen <= 1'b0;
    prev_code <= ~code_out_n; // Undo the inverted keying
    if (priority_n !== 1'b0) begin
      run_cnt <= 1;
    end else if (~code_out_n !== prev_code) begin
      if (prev_code === 1'b1) begin
        hi_len <= run_cnt;
        pulse_seen <= 1'b1;
      end else begin
        lo_len <= run_cnt;
      end
      run_cnt <= 1;
    end else begin
      run_cnt <= run_cnt + 1;
    end
  end
endmodule

// *** verification/channel_verify_code_sequencer_bench.sv ***
// Self-checking bench for the channel verification code sequencer
`timescale 1ns/10ps
module channel_verify_code_sequencer_bench;
  import verify_code_pkg::*;
  // Shortest timebase, taps moved down by S; sync period and delay tick in clocks
  localparam int D = 1;
  localparam int S = 6;
  localparam int SP = (1 << (TAP_SYNC - S)) * D;
  localparam int DT = (1 << (TAP_DELAY - S)) * D;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic [CODE_BITS-1:0] chan_code = '0;
  logic chan_selected = 1'b0;
  logic exec_tone = 1'b0;
  logic fast_mode = 1'b1;
  logic [1:0] speed_sel = 2'h3;
  logic priority_n;
  logic code_out_n;
  logic energize;
  logic pulse_seen;
  int hi_len;
  int lo_len;
  int errors = 0;
  int n_compared = 0;

  // Clock at 20 MHz
  always #25 mclk = ~mclk;

  channel_verify_code_sequencer #(.OSC_DIVIDE(D), .TAP_SHIFT(S)) dut (
    .mclk(mclk),
    .arst_n(arst_n),
    .chan_code(chan_code),
    .chan_selected(chan_selected),
    .exec_tone(exec_tone),
    .fast_mode(fast_mode),
    .speed_sel(speed_sel),
    .priority_n(priority_n),
    .code_out_n(code_out_n),
    .energize(energize)
  );

  ground_decoder_model far_end (
    .mclk(mclk),
    .priority_n(priority_n),
    .code_out_n(code_out_n),
    .pulse_seen(pulse_seen),
    .hi_len(hi_len),
    .lo_len(lo_len)
  );

  // ************************************************************
  // Checking helpers
  // ************************************************************
  task automatic complete_run;
    $display("Compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check(input string what, input int lo, input int hi, input int seen);
    n_compared++;
    if (seen < lo || seen > hi) begin
      errors++;
      $display("Error %s expected %0d..%0d seen %0d", what, lo, hi, seen);
    end
  endtask

  task automatic check_bit(input string what, input logic exp, input logic seen);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %b seen %b", what, exp, seen);
    end
  endtask

  function automatic logic watch(input int which);
    case (which)
      0: return priority_n;
      1: return energize;
      default: return pulse_seen;
    endcase
  endfunction

  // Bounded wait on a falling edge; counts cycles waited
  task automatic wait_for(input int which, input logic lvl, input int bound, output int n);
    n = 0;
    do begin
      @(negedge mclk);
      n++;
      if (n > bound) begin
        errors++;
        $display("Error wait %0d expected %b seen timeout", which, lvl);
        complete_run();
      end
    end while (watch(which) !== lvl);
  endtask

  // High time of bit k of a cycle, most significant bit first
  function automatic int bit_hi(input logic [CODE_BITS-1:0] code, input int k, input int u);
    return (code[CODE_BITS-1-k] === 1'b1) ? 3 * u : u;
  endfunction

  // ************************************************************
  // One whole verification frame: sync, two code cycles, sync
  // ************************************************************
  task automatic run_sequence(input logic [CODE_BITS-1:0] code, input int tap);
    int u;
    int n;
    int k;
    u = (1 << (tap - S)) * D;
    for (int i = 0; i < 20; i++) begin
      wait_for(2, 1'b1, 12 * SP, n);
      k = (i + 8) % 9;
      check_bit("priority held", 1'b0, priority_n);
      if (i == 0 || i == 19) begin
        check("sync high", 3 * SP, 3 * SP, hi_len);
      end else begin
        check("bit high", bit_hi(code, k, u), bit_hi(code, k, u), hi_len);
      end
      if (i == 0) begin
        check("sync wait", 4 * SP, 5 * SP + 4, lo_len);
      end else if (i == 1) begin
        check("first gap", 6 * u - 2, 7 * u + 4, lo_len);
      end else if (i == 10) begin
        check("cycle gap", 6 * u - 2, 8 * u + 4, lo_len);
      end else if (i == 19) begin
        check("closing wait", 4 * SP, 5 * SP + 9 * u, lo_len);
      end else if (k % 3 == 0) begin
        check("group space", 4 * u - 2, 4 * u + 2, lo_len);
      end else begin
        check("bit pause", u - 2, u + 2, lo_len);
      end
    end
    wait_for(0, 1'b1, 5 * u, n);
    check("release", 3 * u - 2, 4 * u + 4, n);
    check_bit("code idle", 1'b1, code_out_n);
  endtask

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    logic [CODE_BITS-1:0] code;
    int n;
    void'($urandom(32'h0C964781));
    repeat (2) @(negedge mclk);
    check_bit("reset priority", 1'b1, priority_n);
    check_bit("reset code", 1'b1, code_out_n);
    check_bit("reset energize", 1'b0, energize);
    arst_n = 1'b1;
    // Corner code: only the first bit set, fastest speed
    code = 9'h100;
    chan_code = code;
    chan_selected = 1'b1;
    wait_for(0, 1'b0, 2048 * DT + 16, n);
    check("select delay", 2047 * DT, 2048 * DT + 8, n);
    run_sequence(code, TAP_FAST32);
    // Execute tone, then removal restarts the frame
    exec_tone = 1'b1;
    wait_for(1, 1'b1, 2048 * DT + 16, n);
    check("energize delay", 2047 * DT, 2048 * DT + 8, n);
    repeat (1000) @(negedge mclk);
    check_bit("energize held", 1'b1, energize);
    check_bit("no restart", 1'b1, priority_n);
    code = 9'($urandom());
    chan_code = code;
    speed_sel = SPEED_X16;
    exec_tone = 1'b0;
    wait_for(1, 1'b0, 8, n);
    wait_for(0, 1'b0, 8, n);
    run_sequence(code, TAP_FAST16);
    // Deselect, then fresh selections at the 8x and at the slow speed
    for (int m = 0; m < 2; m++) begin
      chan_selected = 1'b0;
      repeat (20) @(negedge mclk);
      check_bit("idle deselected", 1'b1, priority_n);
      code = 9'($urandom());
      chan_code = code;
      speed_sel = SPEED_X8;
      fast_mode = (m == 0);
      chan_selected = 1'b1;
      wait_for(0, 1'b0, 2048 * DT + 16, n);
      check("reselect delay", 2047 * DT, 2048 * DT + 8, n);
      run_sequence(code, (m == 0) ? TAP_FAST8 : TAP_SLOW);
    end
    complete_run();
  end
endmodule
